// >>> rtl/gakr_pkg.sv
// constants and types shared by the gate/reset assist block
package gakr_pkg;

	// bus geometry
	localparam int              ADDR_W          = 12;
	localparam int              IDX_W           = 10;

	// register indices, byte address is four times the index
	localparam logic [9:0]      IDX_FAST_GATE   = 10'h092;
	localparam logic [9:0]      IDX_ASSIST_CTRL = 10'h0f0;
	localparam logic [9:0]      IDX_SOFT_LINES  = 10'h0f1;
	localparam logic [9:0]      IDX_STATUS      = 10'h0f2;

	// reset values
	localparam logic [7:0]      CTRL_RESET      = 8'h80;
	localparam logic [7:0]      PORT_RESET      = 8'h24;
	localparam logic [7:0]      SOFT_RESET      = 8'h01;

	// assist control fields
	localparam int              CTRL_CLKSEL_HI  = 7;
	localparam int              CTRL_CLKSEL_LO  = 6;
	localparam int              CTRL_PORT_EN    = 2;
	localparam int              CTRL_HW_GATE    = 1;
	localparam int              CTRL_HW_RESET   = 0;
	localparam logic [7:0]      CTRL_WR_MASK    = 8'hc7;
	localparam logic [1:0]      CLKSEL_12MHZ    = 2'h2;

	// fast gate port fields and the fixed bits of the read value
	localparam int              PORT_GATE_BIT   = 1;
	localparam int              PORT_RESET_BIT  = 0;
	localparam logic [7:0]      PORT_FIXED      = 8'h24;

	// soft line fields
	localparam int              SOFT_GATE_BIT   = 1;
	localparam int              SOFT_RESET_BIT  = 0;

	// status fields
	localparam int              STAT_GATE       = 0;
	localparam int              STAT_RESET_N    = 1;
	localparam int              STAT_BUSY       = 2;
	localparam int              STAT_CLK_OK     = 3;
	localparam int              STAT_PENDING    = 4;

	// controller commands
	localparam logic [7:0]      CMD_GATE        = 8'hd1;
	localparam logic [7:0]      CMD_RESET       = 8'hfe;
	localparam logic [3:0]      CMD_PULSE_HI    = 4'hf;

	// timing
	localparam int              CLK_PERIOD_NS   = 100;
	localparam int              DELAY_MIN_NS    = 14000;
	localparam int              PULSE_MIN_NS    = 6000;
	localparam int              DELAY_CYCLES    = (DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int              PULSE_CYCLES    = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]      DELAY_LOAD      = 8'(DELAY_CYCLES - 1);
	localparam logic [7:0]      PULSE_LOAD      = 8'(PULSE_CYCLES - 1);

	// bus responses
	localparam logic [1:0]      RESP_OKAY       = 2'h0;
	localparam logic [1:0]      RESP_SLVERR     = 2'h2;

	// byte from the keyboard controller, with command or data strobe
	typedef struct packed {
		logic       cmd_strobe;
		logic       data_strobe;
		logic [7:0] value;
	} gakr_kbc_byte_t;

	// reset pulse timer states
	typedef enum logic [2:0] {
		TMR_IDLE  = 3'b001,
		TMR_DELAY = 3'b010,
		TMR_PULSE = 3'b100
	} gakr_timer_state_t;

endpackage : gakr_pkg

// >>> rtl/gakr_pulse_timer.sv
// delayed low pulse generator for the keyboard host reset
`timescale 1ns/1ps
module gakr_pulse_timer (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	input  wire logic with_delay,
	output logic      busy,
	output logic      pulse_low
);

	gakr_pkg::gakr_timer_state_t state;
	logic [7:0]                  count;
	logic [7:0]                  delay_len;
	logic [7:0]                  pulse_len;

	// delay when with_delay is set, then pulse; a start while busy is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= gakr_pkg::TMR_IDLE;
			count <= 8'h00;
		end else begin
			unique case (state)
				gakr_pkg::TMR_IDLE: begin
					if (start && with_delay) begin
						state <= gakr_pkg::TMR_DELAY;
						count <= gakr_pkg::DELAY_LOAD;
					end else if (start) begin
						state <= gakr_pkg::TMR_PULSE;
						count <= gakr_pkg::PULSE_LOAD;
					end
				end
				gakr_pkg::TMR_DELAY: begin
					if (count == 8'h00) begin
						state <= gakr_pkg::TMR_PULSE;
						count <= gakr_pkg::PULSE_LOAD;
					end else begin
						count <= count - 8'h01;
					end
				end
				gakr_pkg::TMR_PULSE: begin
					if (count == 8'h00) begin
						state <= gakr_pkg::TMR_IDLE;
					end else begin
						count <= count - 8'h01;
					end
				end
			endcase
		end
	end

	assign busy      = (state != gakr_pkg::TMR_IDLE);
	assign pulse_low = (state == gakr_pkg::TMR_PULSE);

	// helper: length of the current delay and pulse phases
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			delay_len <= 8'h00;
			pulse_len <= 8'h00;
		end else begin
			delay_len <= (state == gakr_pkg::TMR_DELAY) ? delay_len + 8'h01 : 8'h00;
			pulse_len <= (state == gakr_pkg::TMR_PULSE) ? pulse_len + 8'h01 : 8'h00;
		end
	end

	a_delay_length: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(state == gakr_pkg::TMR_DELAY) |-> delay_len == 8'(gakr_pkg::DELAY_CYCLES))
		else $error("reset delay phase has wrong length");

	a_pulse_length: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(pulse_low) |-> pulse_len == 8'(gakr_pkg::PULSE_CYCLES))
		else $error("reset pulse has wrong length");

	a_busy_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == gakr_pkg::TMR_DELAY && count > 8'h01 && start)
		|=> state == gakr_pkg::TMR_DELAY && count == $past(count) - 8'h01)
		else $error("start restarted a running delay");

	c_delayed_pulse: cover property (@(posedge aclk) disable iff (!aresetn)
		$fell(state == gakr_pkg::TMR_DELAY) ##1 pulse_low);

endmodule : gakr_pulse_timer

// >>> rtl/gakr_top.sv
// gate and keyboard reset assist logic with its AXI4-Lite register slave
//
// Overview of operation
// - control bits 7:6 pick clock, 10 is 12MHz; code only flags 10 in status bit 3, timing stays fixed for a 100 ns clock
// - control bit 2 enables fast gate port
// - control bit 1 lets hardware drive gate
// - control bit 0 lets hardware drive reset
// - byte after D1 sets gate from bit 1
// - same byte sets reset line from bit 0
// - FE: 14us delay, then 6us low reset
// - software or hardware owns lines, never both
// - port enabled: merge port and controller controls
// - port resets 0x24, reserved bits read fixed
// - port bit 1 drives gate level
// - port bit 0 written 0 to 1: delayed reset pulse
// - even Fx command pulses reset low 6us
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module gakr_top (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [11:0]              s_axi_awaddr,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	output logic [1:0]                    s_axi_bresp,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	input  wire logic [11:0]              s_axi_araddr,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	input  wire gakr_pkg::gakr_kbc_byte_t kbc_in,
	output logic                          address_line_gate,
	output logic                          keyboard_host_reset_n
);

	logic [7:0]  ctrl;
	logic        port_gate;
	logic        port_reset_bit;
	logic        sw_gate;
	logic        sw_reset_n;
	logic        gate_cmd_pending;
	logic        hw_gate;
	logic        hw_reset_n;
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_index;
	logic [31:0] w_data;
	logic        w_lane0;
	logic        do_write;
	logic        timer_start;
	logic        timer_with_delay;
	logic        timer_busy;
	logic        pulse_low;
	logic        port_en;
	logic        hw_gate_en;
	logic        hw_reset_en;
	logic        clk_sel_ok;
	logic        cmd_reset;
	logic        cmd_pulse;
	logic        port_pulse_req;
	logic        next_gate;
	logic        next_reset_n;

	// word index of a byte address
	function automatic logic [9:0] gakr_word_index(input logic [11:0] addr);
		return addr[11:2];
	endfunction : gakr_word_index

	// true for any index that holds a register
	function automatic logic gakr_is_mapped(input logic [9:0] idx);
		return (idx == gakr_pkg::IDX_FAST_GATE) || (idx == gakr_pkg::IDX_ASSIST_CTRL)
			|| (idx == gakr_pkg::IDX_SOFT_LINES) || (idx == gakr_pkg::IDX_STATUS);
	endfunction : gakr_is_mapped

	// control field decode
	assign port_en     = ctrl[gakr_pkg::CTRL_PORT_EN];
	assign hw_gate_en  = ctrl[gakr_pkg::CTRL_HW_GATE];
	assign hw_reset_en = ctrl[gakr_pkg::CTRL_HW_RESET];
	assign clk_sel_ok  = ({ctrl[gakr_pkg::CTRL_CLKSEL_HI], ctrl[gakr_pkg::CTRL_CLKSEL_LO]}
		== gakr_pkg::CLKSEL_12MHZ);

	// write channels are taken independently, one each at a time
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign w_lane0       = s_axi_wstrb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			aw_index <= 10'h000;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held  <= 1'b1;
			aw_index <= gakr_word_index(s_axi_awaddr);
		end else if (do_write) begin
			aw_held  <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			w_data <= {s_axi_wdata[31:1], s_axi_wdata[0] & w_lane0};
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// byte lane 0 flag travels with the data word
	logic w_strb0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_strb0 <= 1'b0;
		end else if (s_axi_wvalid && !w_held) begin
			w_strb0 <= w_lane0;
		end
	end

	// write response, error for unmapped words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= gakr_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= gakr_is_mapped(aw_index) ? gakr_pkg::RESP_OKAY
				: gakr_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register stores; only byte lane 0 carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl           <= gakr_pkg::CTRL_RESET;
			port_gate      <= gakr_pkg::PORT_RESET[gakr_pkg::PORT_GATE_BIT];
			port_reset_bit <= gakr_pkg::PORT_RESET[gakr_pkg::PORT_RESET_BIT];
			sw_gate        <= gakr_pkg::SOFT_RESET[gakr_pkg::SOFT_GATE_BIT];
			sw_reset_n     <= gakr_pkg::SOFT_RESET[gakr_pkg::SOFT_RESET_BIT];
		end else if (do_write && w_strb0) begin
			unique case (aw_index)
				gakr_pkg::IDX_ASSIST_CTRL: begin
					ctrl <= w_data[7:0] & gakr_pkg::CTRL_WR_MASK;
				end
				gakr_pkg::IDX_FAST_GATE: begin
					port_gate      <= w_data[gakr_pkg::PORT_GATE_BIT];
					port_reset_bit <= w_data[gakr_pkg::PORT_RESET_BIT];
				end
				gakr_pkg::IDX_SOFT_LINES: begin
					sw_gate    <= w_data[gakr_pkg::SOFT_GATE_BIT];
					sw_reset_n <= w_data[gakr_pkg::SOFT_RESET_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// read path, answered the cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= gakr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= gakr_is_mapped(gakr_word_index(s_axi_araddr))
				? gakr_pkg::RESP_OKAY : gakr_pkg::RESP_SLVERR;
			unique case (gakr_word_index(s_axi_araddr))
				gakr_pkg::IDX_FAST_GATE:
					s_axi_rdata <= {24'h00_0000, gakr_pkg::PORT_FIXED
						| {6'h00, port_gate, port_reset_bit}};
				gakr_pkg::IDX_ASSIST_CTRL:
					s_axi_rdata <= {24'h00_0000, ctrl};
				gakr_pkg::IDX_SOFT_LINES:
					s_axi_rdata <= {30'h0000_0000, sw_gate, sw_reset_n};
				gakr_pkg::IDX_STATUS:
					s_axi_rdata <= {27'h000_0000, gate_cmd_pending, clk_sel_ok, timer_busy,
						keyboard_host_reset_n, address_line_gate};
				default:
					s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// controller command decode
	assign cmd_reset = kbc_in.cmd_strobe && (kbc_in.value == gakr_pkg::CMD_RESET)
		&& hw_reset_en;
	assign cmd_pulse = kbc_in.cmd_strobe && (kbc_in.value[7:4] == gakr_pkg::CMD_PULSE_HI)
		&& !kbc_in.value[0] && (kbc_in.value != gakr_pkg::CMD_RESET) && hw_reset_en;

	// port pulse only on a written 0 to 1 edge of bit 0
	assign port_pulse_req = do_write && w_strb0 && (aw_index == gakr_pkg::IDX_FAST_GATE)
		&& w_data[gakr_pkg::PORT_RESET_BIT] && !port_reset_bit && port_en;

	assign timer_start      = cmd_reset || cmd_pulse || port_pulse_req;
	assign timer_with_delay = !cmd_pulse;

	// gate command arms the next data byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_cmd_pending <= 1'b0;
		end else if (kbc_in.cmd_strobe) begin
			gate_cmd_pending <= (kbc_in.value == gakr_pkg::CMD_GATE);
		end else if (kbc_in.data_strobe) begin
			gate_cmd_pending <= 1'b0;
		end
	end

	// hardware line levels from the byte after the gate command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hw_gate    <= 1'b0;
			hw_reset_n <= 1'b1;
		end else if (kbc_in.data_strobe && gate_cmd_pending) begin
			if (hw_gate_en) begin
				hw_gate <= kbc_in.value[1];
			end
			if (hw_reset_en) begin
				hw_reset_n <= kbc_in.value[0];
			end
		end
	end

	gakr_pulse_timer u_timer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (timer_start),
		.with_delay(timer_with_delay),
		.busy      (timer_busy),
		.pulse_low (pulse_low)
	);

	// one owner per line, then merge gate with the port and reset with the timer pulse
	assign next_gate    = (hw_gate_en ? hw_gate : sw_gate) | (port_en & port_gate);
	assign next_reset_n = (hw_reset_en ? hw_reset_n : sw_reset_n) & !pulse_low;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			address_line_gate     <= 1'b0;
			keyboard_host_reset_n <= 1'b1;
		end else begin
			address_line_gate     <= next_gate;
			keyboard_host_reset_n <= next_reset_n;
		end
	end

	a_port_gate_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(port_en && port_gate) |=> address_line_gate)
		else $error("port gate bit did not raise the gate");

	a_sw_gate_owner: assert property (@(posedge aclk) disable iff (!aresetn)
		(!port_en && !hw_gate_en) |=> address_line_gate == $past(sw_gate))
		else $error("gate not owned by software");

	a_hw_gate_data: assert property (@(posedge aclk) disable iff (!aresetn)
		(kbc_in.data_strobe && gate_cmd_pending && hw_gate_en && !port_en)
		|=> ##1 address_line_gate == $past(kbc_in.value[1], 2))
		else $error("gate did not follow data bit 1");

	a_hw_reset_data: assert property (@(posedge aclk) disable iff (!aresetn)
		(kbc_in.data_strobe && gate_cmd_pending && hw_reset_en) |=> hw_reset_n == $past(kbc_in.value[0]))
		else $error("reset level did not follow data bit 0");

	a_fe_starts: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmd_reset && !timer_busy) |=> (timer_busy && !pulse_low) [*8])
		else $error("reset command did not start a delayed pulse");

	a_sw_reset_owner: assert property (@(posedge aclk) disable iff (!aresetn)
		(!hw_reset_en && !pulse_low) |=> keyboard_host_reset_n == $past(sw_reset_n))
		else $error("reset line not owned by software");

	a_port_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
		(!port_en && !cmd_reset && !cmd_pulse && !timer_busy) |=> !timer_busy)
		else $error("disabled port started a reset pulse");

	a_port_readback: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && gakr_word_index(s_axi_araddr) == gakr_pkg::IDX_FAST_GATE)
		|=> (s_axi_rdata[7:0] & 8'hfc) == gakr_pkg::PORT_FIXED && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("port read shows wrong fixed bits");

	a_pulse_drives: assert property (@(posedge aclk) disable iff (!aresetn)
		pulse_low |=> !keyboard_host_reset_n)
		else $error("pulse did not pull reset low");

	c_fe_reset: cover property (@(posedge aclk) disable iff (!aresetn)
		cmd_reset ##1 timer_busy);
	c_port_reset: cover property (@(posedge aclk) disable iff (!aresetn)
		port_pulse_req ##1 timer_busy);
	c_gate_data: cover property (@(posedge aclk) disable iff (!aresetn)
		kbc_in.data_strobe && gate_cmd_pending && hw_gate_en);
	c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rresp == gakr_pkg::RESP_SLVERR);

endmodule : gakr_top

// >>> testbench/gakr_kbc_model.sv
// keyboard controller byte source feeding the assist block
`timescale 1ns/1ps
module gakr_kbc_model (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               go,
	input  wire logic               is_cmd,
	input  wire logic [7:0]         byte_val,
	output gakr_pkg::gakr_kbc_byte_t kbc_out
);
	// one strobe per request, value line scrambles between bytes
	always @(posedge aclk) begin
		if (!aresetn) begin
			kbc_out <= '0;
		end else if (go) begin
			kbc_out.cmd_strobe  <= is_cmd;
			kbc_out.data_strobe <= !is_cmd;
			kbc_out.value       <= byte_val;
		end else begin
			kbc_out.cmd_strobe  <= 1'h0;
			kbc_out.data_strobe <= 1'h0;
			kbc_out.value       <= ~kbc_out.value;
		end
	end
endmodule : gakr_kbc_model

// >>> testbench/tb_gakr_top.sv
// self-checking bench for the gate and keyboard reset assist block
`timescale 1ns/1ps
module tb_gakr_top;
	localparam logic [11:0] A_PORT = {gakr_pkg::IDX_FAST_GATE, 2'h0};
	localparam logic [11:0] A_CTRL = {gakr_pkg::IDX_ASSIST_CTRL, 2'h0};
	localparam logic [11:0] A_SOFT = {gakr_pkg::IDX_SOFT_LINES, 2'h0};
	localparam logic [11:0] A_STAT = {gakr_pkg::IDX_STATUS, 2'h0};
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [3:0]  strb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        address_line_gate, keyboard_host_reset_n;
	logic        go = 1'h0, is_cmd = 1'h0;
	logic [7:0]  byte_val = 8'h00;
	int          errors = 0, comparisons = 0, seed = 93917;
	gakr_pkg::gakr_kbc_byte_t kbc_in;

	gakr_top uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .kbc_in,
		.address_line_gate, .keyboard_host_reset_n);
	gakr_kbc_model kbc (.aclk, .aresetn, .go, .is_cmd, .byte_val, .kbc_out(kbc_in));

	// free running bench clock, 100 ns period
	always #50 aclk = ~aclk;

	task automatic close_out();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// write one register word, address and data offered together
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw_hs, w_hs, b_hs;
		int   n;
		@(posedge aclk);
		s_axi_awvalid <= 1'h1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'h1;
		s_axi_wdata   <= {24'h00_0000, d};
		s_axi_wstrb   <= strb;
		s_axi_bready  <= 1'h1;
		r = 2'h3;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs  = s_axi_wvalid && s_axi_wready;
			b_hs  = s_axi_bvalid && s_axi_bready;
			if (b_hs) r = s_axi_bresp;
			@(posedge aclk);
			if (aw_hs) s_axi_awvalid <= 1'h0;
			if (w_hs) s_axi_wvalid <= 1'h0;
			if (b_hs) begin
				s_axi_bready <= 1'h0;
				break;
			end
		end
		if (n == 50) begin
			errors++;
			close_out();
		end
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_hs, r_hs;
		int   n;
		@(posedge aclk);
		s_axi_arvalid <= 1'h1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs  = s_axi_rvalid && s_axi_rready;
			d     = s_axi_rdata;
			r     = s_axi_rresp;
			@(posedge aclk);
			if (ar_hs) s_axi_arvalid <= 1'h0;
			if (r_hs) begin
				s_axi_rready <= 1'h0;
				break;
			end
		end
		if (n == 50) begin
			errors++;
			close_out();
		end
	endtask : rd

	task automatic wok(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		check(r, gakr_pkg::RESP_OKAY);
	endtask : wok

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(r, gakr_pkg::RESP_OKAY);
		check(d, exp);
	endtask : rchk

	// returns at the edge where the design takes the byte
	task automatic kbc_send(input logic c, input logic [7:0] v);
		@(posedge aclk);
		go       <= 1'h1;
		is_cmd   <= c;
		byte_val <= v;
		@(posedge aclk);
		go <= 1'h0;
		@(posedge aclk);
	endtask : kbc_send

	task automatic settle();
		repeat (3) @(negedge aclk);
	endtask : settle

	// edges until reset goes low, then edges it stays low
	task automatic measure(input int lim, output logic f, output int dly, output int wid);
		f = 1'h0;
		dly = 0;
		wid = 0;
		while (!f && dly < lim) begin
			@(posedge aclk);
			#1;
			dly++;
			f = (keyboard_host_reset_n === 1'h0);
		end
		while (f && keyboard_host_reset_n === 1'h0 && wid < 1000) begin
			@(posedge aclk);
			#1;
			wid++;
		end
	endtask : measure

	// hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		errors++;
		close_out();
	end

	// main sequence
	initial begin
		logic [31:0] v, s;
		logic [1:0]  r;
		logic        f;
		int          dly, wid;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		check(address_line_gate, 1'h0);
		check(keyboard_host_reset_n, 1'h1);
		rchk(A_CTRL, 32'h0000_0080);
		rchk(A_PORT, 32'h0000_0024);
		rchk(A_SOFT, 32'h0000_0001);
		// lane 0 strobe low: word accepted, register untouched
		strb = 4'he;
		wok(A_SOFT, 8'h02);
		strb = 4'hf;
		rchk(A_SOFT, 32'h0000_0001);
		wr(12'h004, 8'h55, r);
		check(r, gakr_pkg::RESP_SLVERR);
		rd(12'h004, v, r);
		check(r, gakr_pkg::RESP_SLVERR);
		check(v, 32'h0000_0000);
		// every clock select code, other bits random
		for (int i = 0; i < 12; i++) begin
			v = $random(seed);
			if (i < 4) v[7:6] = i[1:0];
			wok(A_CTRL, v[7:0]);
			rchk(A_CTRL, {24'h00_0000, v[7:0] & gakr_pkg::CTRL_WR_MASK});
			rd(A_STAT, s, r);
			check(s[gakr_pkg::STAT_CLK_OK], v[7:6] == gakr_pkg::CLKSEL_12MHZ);
		end
		// hardware paths off: software levels stand
		wok(A_CTRL, 8'h80);
		wok(A_SOFT, 8'h03);
		kbc_send(1'h1, gakr_pkg::CMD_GATE);
		kbc_send(1'h0, 8'h00);
		settle();
		check(address_line_gate, 1'h1);
		check(keyboard_host_reset_n, 1'h1);
		kbc_send(1'h1, gakr_pkg::CMD_RESET);
		measure(200, f, dly, wid);
		check(f, 1'h0);
		// hardware paths on, software levels must not leak through
		wok(A_SOFT, 8'h00);
		wok(A_CTRL, 8'h83);
		repeat (8) begin
			v = $random(seed);
			kbc_send(1'h1, gakr_pkg::CMD_GATE);
			rd(A_STAT, s, r);
			check(s[gakr_pkg::STAT_PENDING], 1'h1);
			kbc_send(1'h0, v[7:0]);
			settle();
			check(address_line_gate, v[1]);
			check(keyboard_host_reset_n, v[0]);
			rd(A_STAT, s, r);
			check(s[gakr_pkg::STAT_GATE], v[1]);
			check(s[gakr_pkg::STAT_RESET_N], v[0]);
			check(s[gakr_pkg::STAT_PENDING], 1'h0);
		end
		kbc_send(1'h1, gakr_pkg::CMD_GATE);
		kbc_send(1'h0, 8'h01);
		settle();
		// delayed pulse, a second request during the delay is dropped
		kbc_send(1'h1, gakr_pkg::CMD_RESET);
		kbc_send(1'h1, gakr_pkg::CMD_RESET);
		measure(300, f, dly, wid);
		check(f, 1'h1);
		// delay phase plus output flop, less the three edges of the second send
		check(dly, gakr_pkg::DELAY_CYCLES - 2);
		check(wid, gakr_pkg::PULSE_CYCLES);
		measure(300, f, dly, wid);
		check(f, 1'h0);
		// pulse command range F0 to FF less FE, only even codes pulse
		for (int c = 8'hf0; c <= 8'hff; c++) begin
			if (c == gakr_pkg::CMD_RESET) continue;
			kbc_send(1'h1, c[7:0]);
			measure(150, f, dly, wid);
			check(f, !c[0]);
			if (f) begin
				check(dly, 1);
				check(wid, gakr_pkg::PULSE_CYCLES);
			end
		end
		// fast gate port merged with hardware paths
		wok(A_CTRL, 8'h87);
		wok(A_PORT, 8'h02);
		settle();
		check(address_line_gate, 1'h1);
		rchk(A_PORT, 32'h0000_0026);
		wok(A_PORT, 8'hd8);
		rchk(A_PORT, 32'h0000_0024);
		settle();
		check(address_line_gate, 1'h0);
		wok(A_PORT, 8'h01);
		measure(300, f, dly, wid);
		check(f, 1'h1);
		check(dly >= gakr_pkg::DELAY_CYCLES, 1'h1);
		check(wid, gakr_pkg::PULSE_CYCLES);
		wok(A_PORT, 8'h01);
		measure(300, f, dly, wid);
		check(f, 1'h0);
		wok(A_PORT, 8'h00);
		wok(A_PORT, 8'h01);
		rd(A_STAT, s, r);
		check(s[gakr_pkg::STAT_BUSY], 1'h1);
		measure(300, f, dly, wid);
		check(f, 1'h1);
		// port disabled: no gate level, no pulse
		wok(A_CTRL, 8'h83);
		wok(A_PORT, 8'h00);
		wok(A_PORT, 8'h02);
		settle();
		check(address_line_gate, 1'h0);
		wok(A_PORT, 8'h03);
		measure(300, f, dly, wid);
		check(f, 1'h0);
		close_out();
	end
endmodule : tb_gakr_top
